// [rtl/uicr_pkg.sv]
// package: offsets, field positions and bus types for the interrupt clear and ident block
package uicr_pkg;

    // ------------------------------------------------------------
    // register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [11:0] OFF_INT_CLEAR   = 12'h044;
    localparam logic [11:0] OFF_INT_STATUS  = 12'h048;
    localparam logic [11:0] OFF_INT_ENABLE  = 12'h04C;
    localparam logic [11:0] OFF_IDENT_FOUR  = 12'hFD0;
    localparam logic [11:0] OFF_IDENT_FIVE  = 12'hFD4;
    localparam logic [11:0] OFF_IDENT_SIX   = 12'hFD8;
    localparam logic [11:0] OFF_IDENT_SEVEN = 12'hFDC;

    // ------------------------------------------------------------
    // field layout of the clear, status and enable registers
    // ------------------------------------------------------------
    localparam int SRC_LSB = 4;
    localparam int SRC_MSB = 10;
    localparam int NSRC    = 7;
    localparam int BIT_RECEIVE  = 4;
    localparam int BIT_TRANSMIT = 5;
    localparam int BIT_TIMEOUT  = 6;
    localparam int BIT_FRAMING  = 7;
    localparam int BIT_PARITY   = 8;
    localparam int BIT_BREAK    = 9;
    localparam int BIT_OVERRUN  = 10;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [6:0]  RST_STATUS = 7'h00;
    localparam logic [6:0]  RST_ENABLE = 7'h00;
    localparam logic [31:0] RST_RDATA  = 32'h0000_0000;
    localparam logic [1:0]  RESP_OKAY  = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [11:0] addr;
        logic [31:0] data;
        logic [3:0]  strb;
    } uicr_wreq_t;

    typedef struct packed {
        logic [31:0] data;
        logic [1:0]  resp;
    } uicr_rrsp_t;

endpackage

// [rtl/uicr_regs.sv]
// module: axi4-lite interrupt clear register, status/enable and read-only ident bytes
`timescale 1ns/1ps

// Summary of operation
// - A 0 written to any clear bit leaves that interrupt untouched; only a 1 acts.
// - Writing 1 to bit 10 of the clear register at 0x044 clears the overrun interrupt.
// - Writing 1 to bit 9 clears the break interrupt, and the bit itself resets to zero.
// - Writing 1 to bit 8 clears the parity interrupt.
// - Writing 1 to bit 7 clears the framing interrupt.
// - Bits 6, 5 and 4 clear the time-out, transmit and receive interrupts.
// - Clear bits 31:11 and 3:0 and ident bits 31:8 are reserved; they read zero here.
// - Each ident register holds a fixed byte in bits 7:0 that nothing can alter.
// - Idents at 0xFD0..0xFDC give bytes of a 32-bit identifier, lowest byte first.
// - A clear removes raw and masked status of its sources; irq drops once no enabled bit stays set and no event arrives in the clearing cycle.
module uicr_regs #(
    parameter logic [31:0] IDENT_CODE = 32'h5A3C_9617 // arbitrary value
) (
    input  wire logic        ref_clk,
    input  wire logic        nrst,
    input  wire logic [6:0]  event_in,
    output logic      [6:0]  clear_pulse,
    output logic      [6:0]  raw_status,
    output logic      [6:0]  masked_status,
    output logic             irq,
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);

    // ------------------------------------------------------------
    // write channel capture
    // ------------------------------------------------------------
    logic              aw_held_q;
    logic              w_held_q;
    logic [11:0]       awaddr_q;
    logic [31:0]       wdata_q;
    logic [3:0]        wstrb_q;
    logic              bvalid_q;
    logic [1:0]        bresp_q;
    logic              aw_take;
    logic              w_take;
    logic              wr_fire;
    uicr_pkg::uicr_wreq_t wreq;

    assign s_axi_awready = !aw_held_q && !bvalid_q;
    assign s_axi_wready  = !w_held_q && !bvalid_q;
    assign aw_take       = s_axi_awvalid && s_axi_awready;
    assign w_take        = s_axi_wvalid && s_axi_wready;
    assign wr_fire       = aw_held_q && w_held_q && !bvalid_q;
    assign wreq          = '{addr: {awaddr_q[11:2], 2'h0},
                             data: wdata_q,
                             strb: wstrb_q};

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            aw_held_q <= 1'b0;
            awaddr_q  <= 12'h000;
        end else if (aw_take) begin
            aw_held_q <= 1'b1;
            awaddr_q  <= s_axi_awaddr;
        end else if (wr_fire) begin
            aw_held_q <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            w_held_q <= 1'b0;
            wdata_q  <= 32'h0000_0000;
            wstrb_q  <= 4'h0;
        end else if (w_take) begin
            w_held_q <= 1'b1;
            wdata_q  <= s_axi_wdata;
            wstrb_q  <= s_axi_wstrb;
        end else if (wr_fire) begin
            w_held_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // write decode
    // ------------------------------------------------------------
    wire wr_clear  = wr_fire && (wreq.addr == uicr_pkg::OFF_INT_CLEAR);
    wire wr_enable = wr_fire && (wreq.addr == uicr_pkg::OFF_INT_ENABLE);
    wire wr_status = wr_fire && (wreq.addr == uicr_pkg::OFF_INT_STATUS);
    wire wr_ident  = wr_fire && (wreq.addr[11:4] == uicr_pkg::OFF_IDENT_FOUR[11:4]);
    wire wr_known  = wr_clear || wr_enable || wr_status || wr_ident;

    // byte lanes 0 and 1 carry bits 4..10; a lane not strobed writes nothing
    wire [15:0] lane_mask = {{8{wreq.strb[1]}}, {8{wreq.strb[0]}}};
    wire [15:0] lane_data = wreq.data[15:0] & lane_mask;

    // only written ones act; reserved bits 31:11 and 3:0 are dropped
    assign clear_pulse = wr_clear ? lane_data[uicr_pkg::SRC_MSB:uicr_pkg::SRC_LSB]
                                  : 7'h00;

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            bvalid_q <= 1'b0;
            bresp_q  <= uicr_pkg::RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_q <= 1'b1;
            bresp_q  <= wr_known ? uicr_pkg::RESP_OKAY : uicr_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp  = bresp_q;

    // ------------------------------------------------------------
    // interrupt status and enable
    // ------------------------------------------------------------
    logic [6:0] status_q;
    logic [6:0] status_d;
    logic [6:0] enable_q;

    // a new event in the clearing cycle wins over the clear
    assign status_d = (status_q & ~clear_pulse) | event_in;

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            status_q <= uicr_pkg::RST_STATUS;
        end else begin
            status_q <= status_d;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            enable_q <= uicr_pkg::RST_ENABLE;
        end else if (wr_enable && wreq.strb[0] && wreq.strb[1]) begin
            enable_q <= wreq.data[uicr_pkg::SRC_MSB:uicr_pkg::SRC_LSB];
        end
    end

    assign raw_status    = status_q;
    assign masked_status = status_q & enable_q;
    assign irq           = |masked_status;

    // ------------------------------------------------------------
    // read channel
    // ------------------------------------------------------------
    logic        rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0]  rresp_q;
    logic [31:0] rd_word;
    logic        rd_hit;
    logic [11:0] rd_addr;

    assign s_axi_arready = !rvalid_q;
    assign rd_addr       = {s_axi_araddr[11:2], 2'h0};

    // ident bytes hard-wired; reserved upper bits read zero
    always_comb begin
        rd_word = 32'h0000_0000;
        rd_hit  = 1'b1;
        unique case (rd_addr)
            uicr_pkg::OFF_INT_CLEAR:   rd_word = 32'h0000_0000;
            uicr_pkg::OFF_INT_STATUS:  rd_word = {21'h0, status_q, 4'h0};
            uicr_pkg::OFF_INT_ENABLE:  rd_word = {21'h0, enable_q, 4'h0};
            uicr_pkg::OFF_IDENT_FOUR:  rd_word = {24'h0, IDENT_CODE[7:0]};
            uicr_pkg::OFF_IDENT_FIVE:  rd_word = {24'h0, IDENT_CODE[15:8]};
            uicr_pkg::OFF_IDENT_SIX:   rd_word = {24'h0, IDENT_CODE[23:16]};
            uicr_pkg::OFF_IDENT_SEVEN: rd_word = {24'h0, IDENT_CODE[31:24]};
            default:                   rd_hit  = 1'b0;
        endcase
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rvalid_q <= 1'b0;
            rdata_q  <= uicr_pkg::RST_RDATA;
            rresp_q  <= uicr_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && !rvalid_q) begin
            rvalid_q <= 1'b1;
            rdata_q  <= rd_word;
            rresp_q  <= rd_hit ? uicr_pkg::RESP_OKAY : uicr_pkg::RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata  = rdata_q;
    assign s_axi_rresp  = rresp_q;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    AST_ZERO_NO_EFFECT: assert property (@(posedge ref_clk) disable iff (!nrst)
        (wr_clear && wreq.strb[1:0] == 2'h3 && !wreq.data[uicr_pkg::BIT_RECEIVE])
        |=> (raw_status[0] == ($past(status_q[0]) | $past(event_in[0]))))
        else $error("zero written to clear bit changed state");
    AST_OVERRUN_CLEAR: assert property (@(posedge ref_clk) disable iff (!nrst)
        (wr_clear && wreq.strb[1] && wreq.data[uicr_pkg::BIT_OVERRUN] && !event_in[6])
        |=> !raw_status[6])
        else $error("overrun not cleared");
    AST_BREAK_CLEAR: assert property (@(posedge ref_clk) disable iff (!nrst)
        (wr_clear && wreq.strb[1] && wreq.data[uicr_pkg::BIT_BREAK] && !event_in[5])
        |=> !raw_status[5])
        else $error("break not cleared");
    AST_PARITY_CLEAR: assert property (@(posedge ref_clk) disable iff (!nrst)
        (wr_clear && wreq.strb[1] && wreq.data[uicr_pkg::BIT_PARITY] && !event_in[4])
        |=> !raw_status[4])
        else $error("parity not cleared");
    AST_FRAMING_CLEAR: assert property (@(posedge ref_clk) disable iff (!nrst)
        (wr_clear && wreq.strb[0] && wreq.data[uicr_pkg::BIT_FRAMING] && !event_in[3])
        |=> !raw_status[3])
        else $error("framing not cleared");
    AST_LOW_CLEAR: assert property (@(posedge ref_clk) disable iff (!nrst)
        (wr_clear && wreq.strb[0] && wreq.data[uicr_pkg::BIT_TRANSMIT] && !event_in[1])
        |=> !raw_status[1])
        else $error("transmit not cleared");
    AST_RESERVED_IGNORED: assert property (@(posedge ref_clk) disable iff (!nrst)
        wr_clear && wreq.data[uicr_pkg::SRC_MSB:uicr_pkg::SRC_LSB] == 7'h00 |-> clear_pulse == 7'h00)
        else $error("reserved clear bits acted");
    AST_IDENT_FIXED: assert property (@(posedge ref_clk) disable iff (!nrst)
        (s_axi_arvalid && !rvalid_q && rd_addr == uicr_pkg::OFF_IDENT_FOUR)
        |=> s_axi_rvalid && s_axi_rdata == {24'h0, IDENT_CODE[7:0]})
        else $error("ident byte four wrong");
    AST_IDENT_TOP: assert property (@(posedge ref_clk) disable iff (!nrst)
        (s_axi_arvalid && !rvalid_q && rd_addr == uicr_pkg::OFF_IDENT_SEVEN)
        |=> s_axi_rdata == {24'h0, IDENT_CODE[31:24]})
        else $error("ident byte seven wrong");
    AST_IRQ_DROPS: assert property (@(posedge ref_clk) disable iff (!nrst)
        (wr_clear && clear_pulse == 7'h7F && event_in == 7'h00) |=> !irq && masked_status == 7'h00)
        else $error("interrupt line still high after full clear");
    AST_IDENT_WRITE_OK: assert property (@(posedge ref_clk) disable iff (!nrst)
        wr_ident |=> s_axi_bvalid && s_axi_bresp == uicr_pkg::RESP_OKAY)
        else $error("ident write reported error");

    AST_TIMEOUT_CLEAR: assert property (@(posedge ref_clk) disable iff (!nrst)
        (wr_clear && wreq.strb[0] && wreq.data[uicr_pkg::BIT_TIMEOUT] && !event_in[2]) |=> !raw_status[2])
        else $error("time-out not cleared");
    AST_RECEIVE_CLEAR: assert property (@(posedge ref_clk) disable iff (!nrst)
        (wr_clear && wreq.strb[0] && wreq.data[uicr_pkg::BIT_RECEIVE] && !event_in[0]) |=> !raw_status[0])
        else $error("receive not cleared");
    // set must win, or a back-to-back event is lost
    AST_SET_WINS: assert property (@(posedge ref_clk) disable iff (!nrst)
        (event_in != 7'h00) |=> ((raw_status & $past(event_in)) == $past(event_in)))
        else $error("event lost against clear");
    AST_NO_EVENT_NO_SET: assert property (@(posedge ref_clk) disable iff (!nrst)
        1'b1 |=> ((raw_status & ~$past(status_q) & ~$past(event_in)) == 7'h00))
        else $error("status set without event");
    AST_STATUS_KEPT: assert property (@(posedge ref_clk) disable iff (!nrst)
        1'b1 |=> (($past(status_q) & ~$past(clear_pulse) & ~raw_status) == 7'h00))
        else $error("status dropped without a written one");
    AST_PULSE_ONLY_CLEAR: assert property (@(posedge ref_clk) disable iff (!nrst)
        !wr_clear |-> clear_pulse == 7'h00)
        else $error("clear pulse outside clear write");
    AST_PULSE_ONE_CYCLE: assert property (@(posedge ref_clk) disable iff (!nrst)
        (clear_pulse != 7'h00) |=> clear_pulse == 7'h00)
        else $error("clear pulse longer than one cycle");
    AST_IDENT_NO_EFFECT: assert property (@(posedge ref_clk) disable iff (!nrst)
        wr_ident |=> $stable(enable_q))
        else $error("ident write changed state");
    AST_ENABLE_WRITE: assert property (@(posedge ref_clk) disable iff (!nrst)
        (wr_enable && wreq.strb[1:0] == 2'h3)
        |=> enable_q == $past(wreq.data[uicr_pkg::SRC_MSB:uicr_pkg::SRC_LSB]))
        else $error("enable write lost");
    AST_ENABLE_PARTIAL: assert property (@(posedge ref_clk) disable iff (!nrst)
        (wr_enable && wreq.strb[1:0] != 2'h3) |=> $stable(enable_q))
        else $error("partial enable write acted");

    // ------------------------------------------------------------
    // assertions: bus handshake
    // ------------------------------------------------------------
    // a master may stall; the answer must not move meanwhile
    AST_BVALID_HOLD: assert property (@(posedge ref_clk) disable iff (!nrst)
        (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer dropped early");
    AST_RVALID_HOLD: assert property (@(posedge ref_clk) disable iff (!nrst)
        (s_axi_rvalid && !s_axi_rready) |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped early");
    AST_AW_BLOCKED: assert property (@(posedge ref_clk) disable iff (!nrst)
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while answer pending");
    AST_AR_BLOCKED: assert property (@(posedge ref_clk) disable iff (!nrst)
        s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while answer pending");
    AST_AW_HELD_BLOCKS: assert property (@(posedge ref_clk) disable iff (!nrst)
        aw_held_q |-> !s_axi_awready)
        else $error("second address taken");
    AST_W_HELD_BLOCKS: assert property (@(posedge ref_clk) disable iff (!nrst)
        w_held_q |-> !s_axi_wready)
        else $error("second data word taken");
    AST_WRITE_ANSWER: assert property (@(posedge ref_clk) disable iff (!nrst)
        wr_fire |=> s_axi_bvalid && !aw_held_q && !w_held_q)
        else $error("write not answered");
    AST_READ_ANSWER: assert property (@(posedge ref_clk) disable iff (!nrst)
        (s_axi_arvalid && s_axi_arready) |=> s_axi_rvalid)
        else $error("read not answered");
    AST_UNMAPPED_WRITE: assert property (@(posedge ref_clk) disable iff (!nrst)
        (wr_fire && !wr_known) |=> s_axi_bresp == uicr_pkg::RESP_SLVERR)
        else $error("unmapped write not refused");
    AST_CLEAR_WRITE_OK: assert property (@(posedge ref_clk) disable iff (!nrst)
        wr_clear |=> s_axi_bresp == uicr_pkg::RESP_OKAY)
        else $error("clear write reported error");

    // ------------------------------------------------------------
    // assertions: read data
    // ------------------------------------------------------------
    AST_IDENT_FIVE: assert property (@(posedge ref_clk) disable iff (!nrst)
        (s_axi_arvalid && !rvalid_q && rd_addr == uicr_pkg::OFF_IDENT_FIVE)
        |=> s_axi_rdata == {24'h0, IDENT_CODE[15:8]})
        else $error("ident byte five wrong");
    AST_IDENT_SIX: assert property (@(posedge ref_clk) disable iff (!nrst)
        (s_axi_arvalid && !rvalid_q && rd_addr == uicr_pkg::OFF_IDENT_SIX)
        |=> s_axi_rdata == {24'h0, IDENT_CODE[23:16]})
        else $error("ident byte six wrong");
    AST_IDENT_RESERVED: assert property (@(posedge ref_clk) disable iff (!nrst)
        (s_axi_arvalid && !rvalid_q && rd_addr[11:4] == uicr_pkg::OFF_IDENT_FOUR[11:4])
        |=> s_axi_rdata[31:8] == 24'h00_0000)
        else $error("ident reserved bits not zero");
    AST_CLEAR_READS_ZERO: assert property (@(posedge ref_clk) disable iff (!nrst)
        (s_axi_arvalid && !rvalid_q && rd_addr == uicr_pkg::OFF_INT_CLEAR)
        |=> s_axi_rdata == 32'h0000_0000 && s_axi_rresp == uicr_pkg::RESP_OKAY)
        else $error("clear register read not zero");
    AST_STATUS_READ: assert property (@(posedge ref_clk) disable iff (!nrst)
        (s_axi_arvalid && !rvalid_q && rd_addr == uicr_pkg::OFF_INT_STATUS)
        |=> s_axi_rdata == {21'h0, $past(status_q), 4'h0})
        else $error("status read wrong");
    AST_READ_UNMAPPED: assert property (@(posedge ref_clk) disable iff (!nrst)
        (s_axi_arvalid && !rvalid_q && !rd_hit) |=> s_axi_rresp == uicr_pkg::RESP_SLVERR)
        else $error("unmapped read not refused");

    // ------------------------------------------------------------
    // cover points
    // ------------------------------------------------------------
    // set and clear in one cycle is rare in software; watch that it is reached
    COV_CLEAR_WRITE: cover property (@(posedge ref_clk) disable iff (!nrst)
        wr_clear && clear_pulse != 7'h00);
    COV_IRQ_CYCLE: cover property (@(posedge ref_clk) disable iff (!nrst)
        irq ##[1:20] !irq);
    COV_IDENT_READ: cover property (@(posedge ref_clk) disable iff (!nrst)
        s_axi_rvalid && s_axi_rready && s_axi_rdata[7:0] == IDENT_CODE[31:24]);
    COV_SET_AND_CLEAR: cover property (@(posedge ref_clk) disable iff (!nrst)
        (clear_pulse & event_in) != 7'h00);
    COV_SLVERR_WRITE: cover property (@(posedge ref_clk) disable iff (!nrst)
        s_axi_bvalid && s_axi_bresp == uicr_pkg::RESP_SLVERR);

endmodule

// [test/tb.sv]
// testbench: bus stimulus and scoreboard for the interrupt clear and ident block
`timescale 1ns/1ps
module tb;
    // ------------------------------------------------------------
    // clock, reset, design hookup
    // ------------------------------------------------------------
    localparam logic [31:0] CODE = 32'hC4E1_2B7D; // arbitrary value
    logic        ref_clk = 1'b0;
    logic        nrst = 1'b0;
    logic [6:0]  event_in = 7'h00;
    logic [6:0]  clear_pulse, raw_status, masked_status, st, en;
    logic        irq, awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
    logic [11:0] awaddr = 12'h000;
    logic [11:0] araddr = 12'h000;
    logic [31:0] wdata = 32'h0000_0000;
    logic [3:0]  wstrb = 4'h0;
    logic        awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
    logic        bready = 1'b1, rready = 1'b1; // never stalls: answers are taken at once
    logic [33:0] exp_q[$];
    logic [6:0]  prev_pulse = 7'h00, pulse_q = 7'h00;
    int          checks = 0, miscompares = 0, seed = 67, i;

    always #5 ref_clk = ~ref_clk;

    uicr_regs #(.IDENT_CODE(CODE)) uut (
        .ref_clk(ref_clk), .nrst(nrst), .event_in(event_in), .clear_pulse(clear_pulse),
        .raw_status(raw_status), .masked_status(masked_status), .irq(irq),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready));

    // ------------------------------------------------------------
    // compare, verdict, bus tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict;
        $display("checks=%0d miscompares=%0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // oldest note against each answer; an empty queue can never match
    task automatic take(input logic [33:0] seen);
        logic [33:0] e;
        e = (exp_q.size() != 0) ? exp_q.pop_front() : 34'h3_FFFF_FFFF;
        chk(seen, e);
    endtask

    always @(posedge ref_clk) begin
        // the pulse stands in the cycle before the write answer
        if (nrst && bvalid && bready) pulse_q = prev_pulse;
        prev_pulse = clear_pulse;
        if (nrst && bvalid && bready) take({32'h0000_0000, bresp});
        if (nrst && rvalid && rready) take({rdata, rresp});
    end

    task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        exp_q.push_back({32'h0000_0000, er});
        awaddr <= a; wdata <= d; wstrb <= 4'hF; awvalid <= 1'b1; wvalid <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge ref_clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        if (n == 50) begin
            miscompares++;
            give_verdict();
        end
    endtask

    task automatic axi_rd(input logic [11:0] a, input logic [33:0] e);
        int n;
        exp_q.push_back(e);
        araddr <= a; arvalid <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge ref_clk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        if (n == 50) begin
            miscompares++;
            give_verdict();
        end
    endtask

    task automatic raise(input logic [6:0] e);
        event_in <= e;
        @(posedge ref_clk);
        event_in <= 7'h00;
        st = st | e;
    endtask

    task automatic do_clear(input logic [31:0] c);
        axi_wr(uicr_pkg::OFF_INT_CLEAR, c, uicr_pkg::RESP_OKAY);
        st = st & ~c[10:4];
        @(posedge ref_clk);
        chk({27'h0, raw_status}, {27'h0, st});
        chk({27'h0, pulse_q}, {27'h0, c[10:4]});
        chk({27'h0, masked_status}, {27'h0, st & en});
        chk({33'h0, irq}, {33'h0, |(st & en)});
        axi_rd(uicr_pkg::OFF_INT_STATUS, {21'h0, st, 4'h0, uicr_pkg::RESP_OKAY});
    endtask

    task automatic set_en(input logic [6:0] v);
        axi_wr(uicr_pkg::OFF_INT_ENABLE, {21'h0, v, 4'h0}, uicr_pkg::RESP_OKAY);
        en = v;
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        st = 7'h00;
        en = 7'h00;
        repeat (16) @(posedge ref_clk);
        nrst <= 1'b1;
        @(posedge ref_clk);
        for (i = 0; i < 4; i++) begin
            axi_rd(uicr_pkg::OFF_IDENT_FOUR + 12'(4 * i), {24'h0, CODE[8*i +: 8], 2'h0});
            axi_wr(uicr_pkg::OFF_IDENT_FOUR + 12'(4 * i), $random(seed), uicr_pkg::RESP_OKAY);
            axi_rd(uicr_pkg::OFF_IDENT_FOUR + 12'(4 * i), {24'h0, CODE[8*i +: 8], 2'h0});
        end
        axi_rd(uicr_pkg::OFF_INT_CLEAR, {32'h0, uicr_pkg::RESP_OKAY});
        axi_rd(12'h100, {32'h0, uicr_pkg::RESP_SLVERR});
        axi_wr(12'h100, 32'hFFFF_FFFF, uicr_pkg::RESP_SLVERR);
        $display("test ident and map done");
        set_en(7'h7F);
        raise(7'h7F);
        do_clear(32'hFFFF_F80F);
        for (i = 0; i < uicr_pkg::NSRC; i++) do_clear(32'h1 << (uicr_pkg::SRC_LSB + i));
        $display("test single clears done");
        for (i = 0; i < 12; i++) begin
            set_en(7'($random(seed)));
            raise(7'($random(seed)));
            do_clear($random(seed));
        end
        $display("test random clears done");
        give_verdict();
    end
endmodule
